// File: design/tdc_pkg.sv
// constants and types shared by the timer dma capture/compare block
package tdc_pkg;
  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_CAP0_HI = 10'h0f0;
  localparam logic [9:0] IDX_CAP0_LO = 10'h0f1;
  localparam logic [9:0] IDX_CAP1_HI = 10'h0f2;
  localparam logic [9:0] IDX_CAP1_LO = 10'h0f3;
  localparam logic [9:0] IDX_CMP0_HI = 10'h0f4;
  localparam logic [9:0] IDX_CMP0_LO = 10'h0f5;
  localparam logic [9:0] IDX_CMP1_HI = 10'h0f6;
  localparam logic [9:0] IDX_CMP1_LO = 10'h0f7;
  localparam logic [9:0] IDX_CNT_PTR = 10'h0e0;
  localparam logic [9:0] IDX_ADR_PTR = 10'h0e1;
  localparam logic [9:0] IDX_MASK = 10'h0e2;
  localparam logic [9:0] IDX_CTRL = 10'h0e3;
  localparam logic [9:0] IDX_FLAG = 10'h0e4;
  localparam logic [9:0] IDX_CP_ADDR = 10'h0e5;
  localparam logic [9:0] IDX_CP_COUNT = 10'h0e6;
  localparam logic [9:0] IDX_CM_ADDR = 10'h0e7;
  localparam logic [9:0] IDX_CM_COUNT = 10'h0e8;
  // pointer register fields
  localparam int PTR_TYPE = 0;
  localparam int PTR_CHAN = 1;
  localparam int PTR_TOG = 2;
  // interrupt/dma mask fields
  localparam int MSK_GLOBAL = 7;
  localparam int MSK_CP_DMA = 3;
  localparam int MSK_CP_IRQ = 2;
  localparam int MSK_CM_DMA = 1;
  localparam int MSK_CM_IRQ = 0;
  // interrupt/dma control fields
  localparam int CTL_CP_EOB = 7;
  localparam int CTL_CM_EOB = 6;
  localparam int CTL_SWAP = 5;
  // timer flag fields
  localparam int FLG_CP_PEND = 3;
  localparam int FLG_CM_PEND = 2;
  localparam int FLG_CP_OVR = 1;
  localparam int FLG_CM_OVR = 0;
  // reset values, address and count steps, alignment pattern
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] ADDR_STEP = 8'h02;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [1:0] ALIGN_OK = 2'b00;
  typedef enum logic [1:0] {ST_IDLE, ST_HIGH, ST_LOW} tdc_state_t;
endpackage : tdc_pkg

// File: design/tdc_timer_dma.sv
// dma capture/compare channels of a 16-bit multifunction timer, apb registers
// Operation
// RULE1: two channels: memory into compare 0, capture 0 out to memory
// RULE2: with dma on, channel interrupt comes only from end of block
// RULE3: capture channel wins over compare channel when both request
// RULE4: each dma request gated by its own mask bit
// RULE5: each end-of-block interrupt enabled by its own mask bit
// RULE6: upper pointer bits form a base shared by both channels
// RULE7: memory mode forces pointer bit 1 low for capture, high for compare
// RULE8: register mode uses one adjacent pair, address pointer unused
// RULE9: each transaction is one word moved as two byte transfers
// RULE10: second byte raised to top priority, restored afterwards
// RULE11: a started word finishes both bytes before the other channel
// RULE12: whole table done resets counter and signals end of block
// RULE13: swap mode inverts toggle bit after every end of block
// RULE14: toggle bits readable and writable, each channel uses its own
// RULE15: swap enable bit turns swap on for both channels
// RULE16: end-of-block interrupt only without pending dma, below overflow
// RULE17: handler reloads pointers, clears flags, then re-enables dma
// RULE18: software writing end-of-block one under swap raises spurious irq
// RULE19: end of block on still-set flag clears that channel dma mask
// RULE20: two capture/load word registers, high and low bytes, no reset
// RULE21: two compare word registers, high and low bytes, reset zero
// RULE22: event before pending flag clears sets the overrun flag
// RULE23: each word advances address by a word, decrements the counter
`timescale 1ns/1ps
module tdc_timer_dma (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [15:0] counter_i,
  input wire logic capture_zero_event_i,
  input wire logic capture_one_event_i,
  input wire logic compare_zero_event_i,
  input wire logic overflow_underflow_irq_i,
  output logic dma_req_o,
  output logic dma_capture_o,
  output logic dma_prio_top_o,
  output logic dma_high_byte_o,
  output logic [7:0] dma_cnt_ptr_o,
  output logic [7:0] dma_addr_ptr_o,
  output logic [7:0] dma_mem_addr_o,
  output logic [7:0] dma_wdata_o,
  input wire logic [7:0] dma_rdata_i,
  input wire logic dma_ack_i,
  output logic [15:0] compare_zero_o,
  output logic [15:0] compare_one_o,
  output logic [15:0] load_zero_o,
  output logic [15:0] load_one_o,
  output logic capture_irq_o,
  output logic compare_irq_o
);
  logic [15:0] cap0_q, cap1_q, cmp0_q, cmp1_q;
  logic [7:0] cnt_ptr_q, adr_ptr_q, mask_q, ctrl_q, flag_q;
  logic [7:0] cp_addr_q, cp_count_q, cm_addr_q, cm_count_q, cmp_buf_q;
  logic [7:0] cnt_ptr_out_q, adr_ptr_out_q, mem_addr_q, wdata_q;
  logic cp_req_q, cm_req_q, chan_q;
  logic [31:0] rdata_q;
  logic err_q;
  tdc_pkg::tdc_state_t state_q;
  logic [9:0] idx;
  logic wr_en, rd_setup, word_done, cp_done, cm_done;
  logic cp_eob_set, cm_eob_set, cp_sw_spur, cm_sw_spur;
  logic start_cp, start_cm, swap;
  logic [31:0] rdata_d;
  logic hit_d;
  logic [7:0] wbyte;

  // one-word-per-register decode; misaligned accesses never hit
  function automatic logic wr_to(input logic [9:0] reg_idx, input logic en,
                                 input logic [9:0] cur);
    wr_to = en && (cur == reg_idx);
  endfunction : wr_to

  assign idx = paddr_i[11:2];
  assign wbyte = pwdata_i[7:0];
  assign wr_en = psel_i && penable_i && pwrite_i && (paddr_i[1:0] == tdc_pkg::ALIGN_OK);
  assign rd_setup = psel_i && !penable_i;
  assign swap = ctrl_q[tdc_pkg::CTL_SWAP]; // [RULE15]

  // zero wait states, error on an unmapped or misaligned address
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && err_q;
  assign prdata_o = rdata_q;

  // read mux, narrow registers sit in the low bits
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    hit_d = 1'b1;
    if (idx == tdc_pkg::IDX_CAP0_HI) rdata_d[7:0] = cap0_q[15:8];
    else if (idx == tdc_pkg::IDX_CAP0_LO) rdata_d[7:0] = cap0_q[7:0];
    else if (idx == tdc_pkg::IDX_CAP1_HI) rdata_d[7:0] = cap1_q[15:8];
    else if (idx == tdc_pkg::IDX_CAP1_LO) rdata_d[7:0] = cap1_q[7:0];
    else if (idx == tdc_pkg::IDX_CMP0_HI) rdata_d[7:0] = cmp0_q[15:8];
    else if (idx == tdc_pkg::IDX_CMP0_LO) rdata_d[7:0] = cmp0_q[7:0];
    else if (idx == tdc_pkg::IDX_CMP1_HI) rdata_d[7:0] = cmp1_q[15:8];
    else if (idx == tdc_pkg::IDX_CMP1_LO) rdata_d[7:0] = cmp1_q[7:0];
    else if (idx == tdc_pkg::IDX_CNT_PTR) rdata_d[7:0] = cnt_ptr_q; // [RULE14]
    else if (idx == tdc_pkg::IDX_ADR_PTR) rdata_d[7:0] = adr_ptr_q; // [RULE14]
    else if (idx == tdc_pkg::IDX_MASK) rdata_d[7:0] = mask_q;
    else if (idx == tdc_pkg::IDX_CTRL) rdata_d[7:0] = ctrl_q;
    else if (idx == tdc_pkg::IDX_FLAG) rdata_d[7:0] = flag_q;
    else if (idx == tdc_pkg::IDX_CP_ADDR) rdata_d[7:0] = cp_addr_q;
    else if (idx == tdc_pkg::IDX_CP_COUNT) rdata_d[7:0] = cp_count_q;
    else if (idx == tdc_pkg::IDX_CM_ADDR) rdata_d[7:0] = cm_addr_q;
    else if (idx == tdc_pkg::IDX_CM_COUNT) rdata_d[7:0] = cm_count_q;
    else hit_d = 1'b0;
    if (paddr_i[1:0] != tdc_pkg::ALIGN_OK) hit_d = 1'b0;
  end

  // read data and decode result captured in the setup cycle
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end
    else if (rd_setup)
    begin
      rdata_q <= rdata_d;
      err_q <= !hit_d;
    end
  end

  // capture/load registers; left unreset as their content is undefined
  always_ff @(posedge ref_clk_i)
  begin
    if (capture_zero_event_i) cap0_q <= counter_i; // [RULE20]
    else if (wr_to(tdc_pkg::IDX_CAP0_HI, wr_en, idx)) cap0_q[15:8] <= wbyte;
    else if (wr_to(tdc_pkg::IDX_CAP0_LO, wr_en, idx)) cap0_q[7:0] <= wbyte;
    if (capture_one_event_i) cap1_q <= counter_i; // [RULE20]
    else if (wr_to(tdc_pkg::IDX_CAP1_HI, wr_en, idx)) cap1_q[15:8] <= wbyte;
    else if (wr_to(tdc_pkg::IDX_CAP1_LO, wr_en, idx)) cap1_q[7:0] <= wbyte;
  end
  assign load_zero_o = cap0_q;
  assign load_one_o = cap1_q;

  // compare registers; a finished compare word lands whole, over software
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      cmp0_q <= tdc_pkg::RST_WORD; // [RULE21]
      cmp1_q <= tdc_pkg::RST_WORD; // [RULE21]
    end
    else
    begin
      if (cm_done) cmp0_q <= {cmp_buf_q, dma_rdata_i}; // [RULE1]
      else if (wr_to(tdc_pkg::IDX_CMP0_HI, wr_en, idx)) cmp0_q[15:8] <= wbyte;
      else if (wr_to(tdc_pkg::IDX_CMP0_LO, wr_en, idx)) cmp0_q[7:0] <= wbyte;
      if (wr_to(tdc_pkg::IDX_CMP1_HI, wr_en, idx)) cmp1_q[15:8] <= wbyte;
      else if (wr_to(tdc_pkg::IDX_CMP1_LO, wr_en, idx)) cmp1_q[7:0] <= wbyte;
    end
  end
  assign compare_zero_o = cmp0_q;
  assign compare_one_o = cmp1_q;

  // word completion and end-of-block detection
  assign word_done = (state_q == tdc_pkg::ST_LOW) && dma_ack_i;
  assign cp_done = word_done && chan_q;
  assign cm_done = word_done && !chan_q;
  assign cp_eob_set = cp_done && (cp_count_q == tdc_pkg::COUNT_ONE); // [RULE12]
  assign cm_eob_set = cm_done && (cm_count_q == tdc_pkg::COUNT_ONE); // [RULE12]
  // a software one into a clear flag sets the pending flag under swap
  assign cp_sw_spur = wr_to(tdc_pkg::IDX_CTRL, wr_en, idx) && swap &&
                      wbyte[tdc_pkg::CTL_CP_EOB] && !ctrl_q[tdc_pkg::CTL_CP_EOB]; // [RULE18]
  assign cm_sw_spur = wr_to(tdc_pkg::IDX_CTRL, wr_en, idx) && swap &&
                      wbyte[tdc_pkg::CTL_CM_EOB] && !ctrl_q[tdc_pkg::CTL_CM_EOB]; // [RULE18]

  // pointer registers; toggle bits flip on end of block in swap mode
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      cnt_ptr_q <= tdc_pkg::RST_BYTE;
      adr_ptr_q <= tdc_pkg::RST_BYTE;
    end
    else
    begin
      if (wr_to(tdc_pkg::IDX_CNT_PTR, wr_en, idx)) cnt_ptr_q <= wbyte;
      if (wr_to(tdc_pkg::IDX_ADR_PTR, wr_en, idx)) adr_ptr_q <= wbyte;
      if (cm_eob_set && swap) cnt_ptr_q[tdc_pkg::PTR_TOG] <= !cnt_ptr_q[tdc_pkg::PTR_TOG]; // [RULE13]
      if (cp_eob_set && swap) adr_ptr_q[tdc_pkg::PTR_TOG] <= !adr_ptr_q[tdc_pkg::PTR_TOG]; // [RULE13]
    end
  end

  // mask register; protection clears the dma mask on a repeated end of block
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i) mask_q <= tdc_pkg::RST_BYTE;
    else
    begin
      if (wr_to(tdc_pkg::IDX_MASK, wr_en, idx)) mask_q <= wbyte;
      if (cp_eob_set && ctrl_q[tdc_pkg::CTL_CP_EOB]) mask_q[tdc_pkg::MSK_CP_DMA] <= 1'b0; // [RULE19]
      if (cm_eob_set && ctrl_q[tdc_pkg::CTL_CM_EOB]) mask_q[tdc_pkg::MSK_CM_DMA] <= 1'b0; // [RULE19]
    end
  end

  // control register; hardware end-of-block set wins over a clearing write
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i) ctrl_q <= tdc_pkg::RST_BYTE;
    else
    begin
      if (wr_to(tdc_pkg::IDX_CTRL, wr_en, idx)) ctrl_q <= wbyte;
      if (cp_eob_set) ctrl_q[tdc_pkg::CTL_CP_EOB] <= 1'b1; // [RULE12]
      if (cm_eob_set) ctrl_q[tdc_pkg::CTL_CM_EOB] <= 1'b1; // [RULE12]
    end
  end

  // flag register: pending from event without dma, or from end of block
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i) flag_q <= tdc_pkg::RST_BYTE;
    else
    begin
      if (wr_to(tdc_pkg::IDX_FLAG, wr_en, idx)) flag_q <= wbyte;
      if ((capture_zero_event_i && !mask_q[tdc_pkg::MSK_CP_DMA]) || cp_eob_set || cp_sw_spur)
        flag_q[tdc_pkg::FLG_CP_PEND] <= 1'b1; // [RULE2]
      if ((compare_zero_event_i && !mask_q[tdc_pkg::MSK_CM_DMA]) || cm_eob_set || cm_sw_spur)
        flag_q[tdc_pkg::FLG_CM_PEND] <= 1'b1; // [RULE2]
      if (capture_zero_event_i && (flag_q[tdc_pkg::FLG_CP_PEND] || cp_req_q))
        flag_q[tdc_pkg::FLG_CP_OVR] <= 1'b1; // [RULE22]
      if (compare_zero_event_i && (flag_q[tdc_pkg::FLG_CM_PEND] || cm_req_q))
        flag_q[tdc_pkg::FLG_CM_OVR] <= 1'b1; // [RULE22]
    end
  end

  // dma requests, each gated by its own mask; a new event wins over service
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      cp_req_q <= 1'b0;
      cm_req_q <= 1'b0;
    end
    else
    begin
      if (capture_zero_event_i && mask_q[tdc_pkg::MSK_CP_DMA]) cp_req_q <= 1'b1; // [RULE4]
      else if (cp_done) cp_req_q <= 1'b0;
      if (compare_zero_event_i && mask_q[tdc_pkg::MSK_CM_DMA]) cm_req_q <= 1'b1; // [RULE4]
      else if (cm_done) cm_req_q <= 1'b0;
    end
  end

  // address and counter; counter rests at zero after the last word
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      cp_addr_q <= tdc_pkg::RST_BYTE;
      cp_count_q <= tdc_pkg::RST_BYTE;
      cm_addr_q <= tdc_pkg::RST_BYTE;
      cm_count_q <= tdc_pkg::RST_BYTE;
    end
    else
    begin
      if (cp_done)
      begin
        cp_addr_q <= cp_addr_q + tdc_pkg::ADDR_STEP; // [RULE23]
        cp_count_q <= cp_count_q - tdc_pkg::COUNT_ONE; // [RULE23]
      end
      else if (wr_to(tdc_pkg::IDX_CP_ADDR, wr_en, idx)) cp_addr_q <= wbyte;
      else if (wr_to(tdc_pkg::IDX_CP_COUNT, wr_en, idx)) cp_count_q <= wbyte;
      if (cm_done)
      begin
        cm_addr_q <= cm_addr_q + tdc_pkg::ADDR_STEP; // [RULE23]
        cm_count_q <= cm_count_q - tdc_pkg::COUNT_ONE; // [RULE23]
      end
      else if (wr_to(tdc_pkg::IDX_CM_ADDR, wr_en, idx)) cm_addr_q <= wbyte;
      else if (wr_to(tdc_pkg::IDX_CM_COUNT, wr_en, idx)) cm_count_q <= wbyte;
    end
  end

  // arbitration: capture first, only from idle so a word is never split
  assign start_cp = cp_req_q && mask_q[tdc_pkg::MSK_CP_DMA]; // [RULE3]
  assign start_cm = cm_req_q && mask_q[tdc_pkg::MSK_CM_DMA] && !start_cp; // [RULE3]

  // word sequencer: high byte then low byte, channel locked throughout
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      state_q <= tdc_pkg::ST_IDLE;
      chan_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        tdc_pkg::ST_IDLE:
        begin
          if (start_cp || start_cm)
          begin
            chan_q <= start_cp;
            state_q <= tdc_pkg::ST_HIGH; // [RULE9]
          end
        end
        tdc_pkg::ST_HIGH:
        begin
          if (dma_ack_i) state_q <= tdc_pkg::ST_LOW; // [RULE11]
        end
        tdc_pkg::ST_LOW:
        begin
          if (dma_ack_i) state_q <= tdc_pkg::ST_IDLE; // [RULE9]
        end
        default: state_q <= tdc_pkg::ST_IDLE;
      endcase
    end
  end

  // byte data: capture bytes driven out, compare high byte held for the word
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      wdata_q <= tdc_pkg::RST_BYTE;
      cmp_buf_q <= tdc_pkg::RST_BYTE;
    end
    else
    begin
      if (state_q == tdc_pkg::ST_IDLE) wdata_q <= cap0_q[15:8]; // [RULE1]
      else if (state_q == tdc_pkg::ST_HIGH && dma_ack_i) wdata_q <= cap0_q[7:0];
      if (state_q == tdc_pkg::ST_HIGH && dma_ack_i && !chan_q) cmp_buf_q <= dma_rdata_i;
    end
  end

  // pointer addresses latched at word start, so mid-word writes cannot skew them
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      cnt_ptr_out_q <= tdc_pkg::RST_BYTE;
      adr_ptr_out_q <= tdc_pkg::RST_BYTE;
      mem_addr_q <= tdc_pkg::RST_BYTE;
    end
    else if (state_q == tdc_pkg::ST_IDLE && (start_cp || start_cm))
    begin
      mem_addr_q <= start_cp ? cp_addr_q : cm_addr_q;
      // shared base, own toggle bit per channel
      cnt_ptr_out_q[7:3] <= cnt_ptr_q[7:3]; // [RULE6]
      adr_ptr_out_q[7:3] <= cnt_ptr_q[tdc_pkg::PTR_TYPE] ? cnt_ptr_q[7:3] : adr_ptr_q[7:3]; // [RULE6]
      cnt_ptr_out_q[tdc_pkg::PTR_TOG] <= start_cp ? adr_ptr_q[tdc_pkg::PTR_TOG] :
                                         cnt_ptr_q[tdc_pkg::PTR_TOG]; // [RULE14]
      adr_ptr_out_q[tdc_pkg::PTR_TOG] <= start_cp ? adr_ptr_q[tdc_pkg::PTR_TOG] :
                                         cnt_ptr_q[tdc_pkg::PTR_TOG]; // [RULE14]
      cnt_ptr_out_q[tdc_pkg::PTR_TYPE] <= 1'b0;
      adr_ptr_out_q[tdc_pkg::PTR_TYPE] <= cnt_ptr_q[tdc_pkg::PTR_TYPE]; // [RULE8]
      if (cnt_ptr_q[tdc_pkg::PTR_TYPE])
      begin
        cnt_ptr_out_q[tdc_pkg::PTR_CHAN] <= !start_cp; // [RULE8]
        adr_ptr_out_q[tdc_pkg::PTR_CHAN] <= !start_cp; // [RULE8]
      end
      else
      begin
        cnt_ptr_out_q[tdc_pkg::PTR_CHAN] <= !start_cp; // [RULE7]
        adr_ptr_out_q[tdc_pkg::PTR_CHAN] <= !start_cp; // [RULE7]
      end
    end
  end

  // dma controller handshake
  assign dma_req_o = (state_q != tdc_pkg::ST_IDLE);
  assign dma_capture_o = chan_q;
  assign dma_high_byte_o = (state_q == tdc_pkg::ST_HIGH);
  assign dma_prio_top_o = (state_q == tdc_pkg::ST_LOW); // [RULE10]
  assign dma_cnt_ptr_o = cnt_ptr_out_q;
  assign dma_addr_ptr_o = adr_ptr_out_q;
  assign dma_mem_addr_o = mem_addr_q;
  assign dma_wdata_o = wdata_q;

  // interrupts wait while any dma request is open and yield to overflow
  assign capture_irq_o = flag_q[tdc_pkg::FLG_CP_PEND] && mask_q[tdc_pkg::MSK_CP_IRQ] &&
                         mask_q[tdc_pkg::MSK_GLOBAL] && !cp_req_q && !cm_req_q &&
                         !overflow_underflow_irq_i; // [RULE5] [RULE16]
  assign compare_irq_o = flag_q[tdc_pkg::FLG_CM_PEND] && mask_q[tdc_pkg::MSK_CM_IRQ] &&
                         mask_q[tdc_pkg::MSK_GLOBAL] && !cp_req_q && !cm_req_q &&
                         !overflow_underflow_irq_i; // [RULE5] [RULE16]
endmodule : tdc_timer_dma

// File: tb/tdc_timer_dma_monitor.sv
// checker for dma byte sequencing and interrupt gating at the block ports
`timescale 1ns/1ps
module tdc_timer_dma_monitor (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic overflow_underflow_irq_i,
  input wire logic dma_req_o,
  input wire logic dma_capture_o,
  input wire logic dma_prio_top_o,
  input wire logic dma_high_byte_o,
  input wire logic [7:0] dma_cnt_ptr_o,
  input wire logic dma_ack_i,
  input wire logic capture_irq_o,
  input wire logic compare_irq_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  // the two byte steps of one word
  sequence s_high_done;
    dma_req_o && dma_high_byte_o && dma_ack_i;
  endsequence
  sequence s_low_done;
    dma_req_o && dma_prio_top_o && dma_ack_i;
  endsequence
  a_word_starts_high: assert property ($rose(dma_req_o) |-> dma_high_byte_o && !dma_prio_top_o)
    else $error("word did not start with the high byte");
  a_req_held_ack: assert property (dma_req_o && !dma_ack_i |=> dma_req_o)
    else $error("request dropped before its byte was done");
  a_second_byte_top: assert property (s_high_done |=> dma_req_o && dma_prio_top_o && !dma_high_byte_o)
    else $error("second byte not raised to top priority");
  a_word_ends_idle: assert property (s_low_done |=> !dma_req_o && !dma_prio_top_o)
    else $error("top priority kept after the word");
  a_channel_kept: assert property (dma_req_o && !(dma_prio_top_o && dma_ack_i) |=> $stable(dma_capture_o) && $stable(dma_cnt_ptr_o))
    else $error("channel switched inside a word");
  a_ptr_chan_bit: assert property (dma_req_o |-> dma_cnt_ptr_o[1] == !dma_capture_o)
    else $error("pointer bit 1 does not match the channel");
  a_irq_below_ovf: assert property (overflow_underflow_irq_i |-> !capture_irq_o && !compare_irq_o)
    else $error("channel interrupt shown over overflow");
  a_irq_no_dma: assert property (dma_req_o |-> !capture_irq_o && !compare_irq_o)
    else $error("channel interrupt shown during a transfer");
endmodule : tdc_timer_dma_monitor

bind tdc_timer_dma tdc_timer_dma_monitor u_mon (
  .ref_clk_i(ref_clk_i),
  .rst_i(rst_i),
  .overflow_underflow_irq_i(overflow_underflow_irq_i),
  .dma_req_o(dma_req_o),
  .dma_capture_o(dma_capture_o),
  .dma_prio_top_o(dma_prio_top_o),
  .dma_high_byte_o(dma_high_byte_o),
  .dma_cnt_ptr_o(dma_cnt_ptr_o),
  .dma_ack_i(dma_ack_i),
  .capture_irq_o(capture_irq_o),
  .compare_irq_o(compare_irq_o)
);

// File: tb/tdc_dma_partner.sv
// model of the core dma controller and memory serving the timer channels
`timescale 1ns/1ps
module tdc_dma_partner (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic high_i,
  input wire logic capture_i,
  input wire logic [7:0] wdata_i,
  input wire logic [15:0] word_i,
  input wire logic [3:0] delay_i,
  output logic ack_o,
  output logic [7:0] rdata_o,
  output logic [15:0] stored_o
);
  logic [3:0] wait_q;
  logic [7:0] pat_q;
  // one ack pulse per byte after delay_i+1 idle cycles, never two in a row
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !req_i || ack_o)
    begin
      ack_o <= 1'b0;
      wait_q <= 4'h0;
    end
    else if (wait_q == delay_i)
      ack_o <= 1'b1;
    else
      wait_q <= wait_q + 4'h1;
  end
  // memory keeps capture bytes, high first, so a word lands whole
  always_ff @(posedge clk_i)
  begin
    pat_q <= pat_q + 8'h01;
    if (rst_i)
      pat_q <= 8'h00;
    if (ack_o && capture_i)
      stored_o <= {stored_o[7:0], wdata_i};
  end
  // outside an ack the bus carries a moving pattern, not stale data
  assign rdata_o = ack_o ? (high_i ? word_i[15:8] : word_i[7:0]) : pat_q;
endmodule : tdc_dma_partner

// File: tb/tb_tdc_timer_dma.sv
// self-checking bench for the timer dma block over apb
`timescale 1ns/1ps
module tb_tdc_timer_dma;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, last_err;
  logic [15:0] counter = 16'h0000;
  logic cap_ev = 1'b0, cmp_ev = 1'b0, ovf = 1'b0;
  logic req, cap, prio, hib, ack, cap_irq, cmp_irq;
  logic [7:0] cptr, aptr, maddr, wdata, rdata;
  logic [15:0] cmp0, cmp1, ld0, ld1, stored;
  logic [15:0] word = 16'hbeef;
  logic [3:0] delay = 4'h0;
  int num_errors = 0;
  int total_checks = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  tdc_timer_dma u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .counter_i(counter), .capture_zero_event_i(cap_ev),
    .capture_one_event_i(cap_ev), .compare_zero_event_i(cmp_ev), .overflow_underflow_irq_i(ovf),
    .dma_req_o(req), .dma_capture_o(cap), .dma_prio_top_o(prio), .dma_high_byte_o(hib),
    .dma_cnt_ptr_o(cptr), .dma_addr_ptr_o(aptr), .dma_mem_addr_o(maddr), .dma_wdata_o(wdata),
    .dma_rdata_i(rdata), .dma_ack_i(ack), .compare_zero_o(cmp0), .compare_one_o(cmp1),
    .load_zero_o(ld0), .load_one_o(ld1), .capture_irq_o(cap_irq), .compare_irq_o(cmp_irq));
  tdc_dma_partner u_far (.clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req), .high_i(hib),
    .capture_i(cap), .wdata_i(wdata), .word_i(word), .delay_i(delay), .ack_o(ack),
    .rdata_o(rdata), .stored_o(stored));
  task automatic end_sim;
    if (num_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic [9:0] idx, input logic wr, input logic [7:0] wd);
    int n;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= {idx, 2'b00};
    pwrite <= wr;
    pwdata <= {24'h00_0000, wd};
    @(posedge ref_clk_i);
    penable <= 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge ref_clk_i);
      if (pready === 1'b1)
        break;
    end
    if (n == 16)
    begin
      num_errors++;
      end_sim();
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
    apb(idx, 1'b1, wd);
  endtask : wr
  task automatic rdc(input string name, input logic [9:0] idx, input logic [7:0] exp);
    apb(idx, 1'b0, 8'h00);
    chk(name, rd[15:0], {8'h00, exp});
  endtask : rdc
  task automatic pulse(input logic c, input logic m);
    @(posedge ref_clk_i);
    cap_ev <= c;
    cmp_ev <= m;
    @(posedge ref_clk_i);
    cap_ev <= 1'b0;
    cmp_ev <= 1'b0;
  endtask : pulse
  // sampled on the falling edge so flop updates have landed
  task automatic wait_req(input logic lvl);
    int n;
    for (n = 0; n < 200; n++)
    begin
      @(negedge ref_clk_i);
      if (req === lvl)
        break;
    end
    if (n == 200)
    begin
      num_errors++;
      end_sim();
    end
  endtask : wait_req
  task automatic run_word;
    wait_req(1'b1);
    wait_req(1'b0);
  endtask : run_word
  initial
  begin
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (int i = 4; i < 8; i++)
      rdc("compare byte", tdc_pkg::IDX_CAP0_HI + 10'(i), 8'h00);
    wr(tdc_pkg::IDX_CAP1_HI, 8'h5a);
    wr(tdc_pkg::IDX_CAP1_LO, 8'ha5);
    rdc("load one hi", tdc_pkg::IDX_CAP1_HI, 8'h5a);
    wr(tdc_pkg::IDX_CMP1_HI, 8'h12);
    wr(tdc_pkg::IDX_CMP1_LO, 8'h34);
    @(negedge ref_clk_i);
    chk("load one", ld1, 16'h5aa5);
    chk("compare one", cmp1, 16'h1234);
    apb(10'h0ff, 1'b0, 8'h00);
    chk("unmapped err", 16'(last_err), 16'h0001);
    chk("unmapped data", rd[15:0], 16'h0000);
    // two-word capture block with swap on
    wr(tdc_pkg::IDX_CTRL, 8'h20);
    wr(tdc_pkg::IDX_CNT_PTR, 8'ha8);
    wr(tdc_pkg::IDX_ADR_PTR, 8'hb0);
    wr(tdc_pkg::IDX_CP_ADDR, 8'h40);
    wr(tdc_pkg::IDX_CP_COUNT, 8'h02);
    wr(tdc_pkg::IDX_MASK, 8'h8c);
    counter <= 16'h1234;
    pulse(1'b1, 1'b0);
    wait_req(1'b1);
    chk("cap cnt ptr", cptr, 16'h00a8);
    chk("cap adr ptr", aptr, 16'h00b0);
    chk("cap mem addr", maddr, 16'h0040);
    wait_req(1'b0);
    chk("capture word", stored, 16'h1234);
    chk("load zero", ld0, 16'h1234);
    chk("load one cap", ld1, 16'h1234);
    chk("mid irq", 16'(cap_irq), 16'h0000);
    rdc("cap addr", tdc_pkg::IDX_CP_ADDR, 8'h42);
    rdc("cap count", tdc_pkg::IDX_CP_COUNT, 8'h01);
    delay <= 4'h3;
    counter <= 16'h5678;
    pulse(1'b1, 1'b0);
    run_word();
    chk("capture word", stored, 16'h5678);
    rdc("count reset", tdc_pkg::IDX_CP_COUNT, 8'h00);
    rdc("eob flag", tdc_pkg::IDX_CTRL, 8'ha0);
    rdc("cap toggle", tdc_pkg::IDX_ADR_PTR, 8'hb4);
    rdc("cmp toggle", tdc_pkg::IDX_CNT_PTR, 8'ha8);
    @(negedge ref_clk_i);
    chk("eob irq", 16'(cap_irq), 16'h0001);
    @(posedge ref_clk_i);
    ovf <= 1'b1;
    @(negedge ref_clk_i);
    chk("irq under ovf", 16'(cap_irq), 16'h0000);
    @(posedge ref_clk_i);
    ovf <= 1'b0;
    // second end of block while the flag is still set
    wr(tdc_pkg::IDX_CP_COUNT, 8'h01);
    pulse(1'b1, 1'b0);
    run_word();
    rdc("protect mask", tdc_pkg::IDX_MASK, 8'h84);
    // handler order: flag, pending, then dma mask back on
    wr(tdc_pkg::IDX_CTRL, 8'h20);
    wr(tdc_pkg::IDX_FLAG, 8'h00);
    wr(tdc_pkg::IDX_CP_COUNT, 8'h05);
    wr(tdc_pkg::IDX_CM_ADDR, 8'h60);
    wr(tdc_pkg::IDX_CM_COUNT, 8'h05);
    wr(tdc_pkg::IDX_CNT_PTR, 8'ha9);
    wr(tdc_pkg::IDX_MASK, 8'h8a);
    pulse(1'b1, 1'b1);
    wait_req(1'b1);
    chk("first channel", 16'(cap), 16'h0001);
    chk("reg adr ptr", aptr, 16'h00a9);
    chk("cap mem addr", maddr, 16'h0046);
    wait_req(1'b0);
    wait_req(1'b1);
    chk("cmp cnt ptr", cptr, 16'h00aa);
    chk("cmp mem addr", maddr, 16'h0060);
    wait_req(1'b0);
    chk("compare zero", cmp0, 16'hbeef);
    rdc("compare hi", tdc_pkg::IDX_CMP0_HI, 8'hbe);
    // dma masked: event only pends, a second one overruns
    wr(tdc_pkg::IDX_FLAG, 8'h00);
    wr(tdc_pkg::IDX_MASK, 8'h80);
    pulse(1'b0, 1'b1);
    repeat (3) @(negedge ref_clk_i);
    chk("masked req", 16'(req), 16'h0000);
    pulse(1'b0, 1'b1);
    rdc("overrun", tdc_pkg::IDX_FLAG, 8'h05);
    // software eob write under swap gives a spurious interrupt
    wr(tdc_pkg::IDX_FLAG, 8'h00);
    wr(tdc_pkg::IDX_MASK, 8'h81);
    wr(tdc_pkg::IDX_CTRL, 8'h60);
    @(negedge ref_clk_i);
    chk("spurious irq", 16'(cmp_irq), 16'h0001);
    end_sim();
  end
endmodule : tb_tdc_timer_dma
